// ==== hw/hbacap_cfg.svh ====
`ifndef HBACAP_CFG_SVH
`define HBACAP_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define HBACAP_ADDR_W 8
`define HBACAP_OFS_CAPS 8'h00

// ----------------------------------------
// field positions inside the capability word
// ----------------------------------------
`define HBACAP_SPD_HI 23
`define HBACAP_SPD_LO 20
`define HBACAP_RSVD_BIT 19
`define HBACAP_NATIVE_BIT 18
`define HBACAP_MULT_BIT 17
`define HBACAP_FRAME_BIT 16
`define HBACAP_PIO_BIT 15
`define HBACAP_DEEP_BIT 14
`define HBACAP_LIGHT_BIT 13
`define HBACAP_SLOT_HI 12
`define HBACAP_SLOT_LO 8
`define HBACAP_COAL_BIT 7
`define HBACAP_ENCL_BIT 6
`define HBACAP_EXT_BIT 5
`define HBACAP_PORT_HI 4
`define HBACAP_PORT_LO 0

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define HBACAP_SPEED_GEN1 4'h1
`define HBACAP_SPEED_GEN2 4'h2
`define HBACAP_SPEED_GEN3 4'h3
`define HBACAP_SPEED_FALLBACK 4'h1
`define HBACAP_WORD_RESET 32'h0000_0000
`define HBACAP_PIO_MULTI_HW 1'h1
`define HBACAP_PORT_MIN_M1 5'h00

`endif

// ==== hw/hbacap_pkg.sv ====
package hbacap_pkg;

  typedef enum logic [0:0] {
    HBACAP_PH_LOAD,
    HBACAP_PH_RUN
  } hbacap_phase_t;

  typedef struct packed {
    logic [3:0] max_link_speed;
    logic native_only_flag;
    logic multiplier_supported;
    logic frame_switching_supported;
    logic multi_block_pio;
    logic deep_sleep_capable;
    logic light_sleep_capable;
    logic [4:0] slot_count_m1;
    logic coalescing_supported;
    logic enclosure_mgmt_supported;
    logic external_port_present;
    logic [4:0] port_count_m1;
  } hbacap_fields_t;

  typedef struct packed {
    hbacap_phase_t phase;
    hbacap_fields_t fields;
    logic ack;
  } hbacap_state_t;

  typedef struct packed {
    logic [31:0] word;
    logic [31:0] rdata;
  } hbacap_word_state_t;

endpackage

// ==== hw/hbacap_word_reg.sv ====
`timescale 1ns/1ps
`include "hbacap_cfg.svh"

module hbacap_word_reg (
  input wire logic clk, // 125 MHz host clock
  input wire logic rst_n, // async reset, active low
  input wire logic load, // one-cycle pulse: take load_word
  input wire logic [31:0] load_word, // assembled capability word
  input wire logic rd_hit, // read of the capability offset
  output logic [31:0] rd_data // registered read data
);
  import hbacap_pkg::*;

  hbacap_word_state_t st_r;
  hbacap_word_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.word = load_word;
    end
    // a miss returns zero, so unmapped reads are clean
    st_nxt.rdata = rd_hit ? st_r.word : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {`HBACAP_WORD_RESET, 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;

endmodule // hbacap_word_reg

// ==== hw/hbacap_top.sv ====
// Functional notes
// [RQ1] capability word readable at offset 00h
// [RQ2] bits 23:20 report max speed, legal encodings
// [RQ3] bit 18 one when native mechanism only
// [RQ4] bit 17 reports port multiplier support
// [RQ5] bit 16 set only with multiplier support
// [RQ6] bit 15 reports multi-block programmed IO
// [RQ7] multi-block programmed IO hardwired to one
// [RQ8] bit 14 reports deep sleep capability
// [RQ9] software avoids deep sleep when unsupported
// [RQ10] bit 13 reports light sleep capability
// [RQ11] software avoids light sleep when unsupported
// [RQ12] bits 12:8 hold slot count minus one
// [RQ13] every port gets the reported slot count
// [RQ14] bit 7 tracks coalescing register presence
// [RQ15] bit 6 tracks enclosure register presence
// [RQ16] bit 5 flags externally reachable ports
// [RQ17] bits 4:0 hold port count minus one
// [RQ18] port count encoding zero means one port
// [RQ19] port count may exceed available bitmap
// [RQ20] word is read-only, writes ignored
// [RQ21] reserved bit 19 reads zero
`timescale 1ns/1ps
`include "hbacap_cfg.svh"

module hbacap_top (
  input wire logic clk, // 125 MHz host clock
  input wire logic rst_n, // async reset, active low
  input wire logic [`HBACAP_ADDR_W-1:0] reg_addr, // byte address in global space
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic [31:0] reg_wdata, // write data, never stored
  output logic [31:0] reg_rdata, // read data, registered
  output logic reg_ack, // access done, one cycle
  input wire logic [3:0] strap_max_speed, // speed strap
  input wire logic strap_native_only, // no legacy interface
  input wire logic strap_multiplier, // multiplier strap
  input wire logic strap_frame_switch, // frame switching strap
  input wire logic strap_deep_sleep, // deep sleep strap
  input wire logic strap_light_sleep, // light sleep strap
  input wire logic [4:0] strap_slot_count_m1, // slots minus one strap
  input wire logic strap_coalescing, // coalescing strap
  input wire logic strap_enclosure, // enclosure strap
  input wire logic strap_external_port, // external connector strap
  input wire logic [4:0] strap_port_count_m1, // ports minus one strap
  output logic caps_valid, // fields captured
  output logic [3:0] max_link_speed, // reported speed
  output logic native_only_flag, // no legacy interface
  output logic multiplier_supported, // multiplier allowed
  output logic frame_switching_supported, // frame switching
  output logic multi_block_pio, // multi-block pio
  output logic deep_sleep_capable, // deep sleep allowed
  output logic light_sleep_capable, // light sleep allowed
  output logic [4:0] slot_count_m1, // slots per port minus one
  output logic coalescing_regs_present, // coalescing regs exist
  output logic enclosure_regs_present, // enclosure regs exist
  output logic external_port_present, // external ports exist
  output logic [4:0] port_count_m1 // silicon ports minus one
);
  import hbacap_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  hbacap_state_t st_r;
  hbacap_state_t st_nxt;
  hbacap_fields_t strap_fields;
  logic rd_hit;
  logic load_pulse;
  logic [31:0] cap_word;
  logic [31:0] word_rdata;
  logic [3:0] speed_clean;

  // ----------------------------------------
  // strap clean-up
  // ----------------------------------------
  // a reserved speed strap would mislead the driver, so fall back to gen 1
  always_comb begin
    case (strap_max_speed)
      `HBACAP_SPEED_GEN1: speed_clean = `HBACAP_SPEED_GEN1; // see RQ2
      `HBACAP_SPEED_GEN2: speed_clean = `HBACAP_SPEED_GEN2;
      `HBACAP_SPEED_GEN3: speed_clean = `HBACAP_SPEED_GEN3;
      default: speed_clean = `HBACAP_SPEED_FALLBACK;
    endcase
  end

  always_comb begin
    strap_fields = '0;
    strap_fields.max_link_speed = speed_clean;
    strap_fields.native_only_flag = strap_native_only; // see RQ3
    strap_fields.multiplier_supported = strap_multiplier; // see RQ4
    // frame switching without a multiplier is meaningless; masked here
    strap_fields.frame_switching_supported = strap_frame_switch & strap_multiplier; // see RQ5
    strap_fields.multi_block_pio = `HBACAP_PIO_MULTI_HW; // see RQ6 see RQ7
    strap_fields.deep_sleep_capable = strap_deep_sleep; // see RQ8
    strap_fields.light_sleep_capable = strap_light_sleep; // see RQ10
    strap_fields.slot_count_m1 = strap_slot_count_m1; // see RQ12
    strap_fields.coalescing_supported = strap_coalescing; // see RQ14
    strap_fields.enclosure_mgmt_supported = strap_enclosure; // see RQ15
    strap_fields.external_port_present = strap_external_port; // see RQ16
    // any 5-bit value is legal, zero being the single-port minimum
    strap_fields.port_count_m1 = strap_port_count_m1; // see RQ17 see RQ18
  end

  // ----------------------------------------
  // sequencing and bus
  // ----------------------------------------
  // decode ignores the byte lanes of the word
  assign rd_hit = reg_rd && (reg_addr[`HBACAP_ADDR_W-1:2] == 6'(`HBACAP_OFS_CAPS >> 2)); // see RQ1
  assign load_pulse = (st_r.phase == HBACAP_PH_LOAD);

  always_comb begin
    st_nxt = st_r;
    // writes are acknowledged but nothing takes reg_wdata
    st_nxt.ack = reg_rd | reg_wr; // see RQ20
    case (st_r.phase)
      HBACAP_PH_LOAD: begin
        // straps are caught on the first edge after reset release
        st_nxt.fields = strap_fields;
        st_nxt.phase = HBACAP_PH_RUN;
      end
      HBACAP_PH_RUN: begin
        st_nxt.fields = st_r.fields; // see RQ20
      end
      default: begin
        st_nxt.phase = HBACAP_PH_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{phase: HBACAP_PH_LOAD, fields: '0, ack: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // word assembly
  // ----------------------------------------
  // upper capability bits 31:24 are not provided and read zero
  always_comb begin
    cap_word = `HBACAP_WORD_RESET;
    cap_word[`HBACAP_SPD_HI:`HBACAP_SPD_LO] = strap_fields.max_link_speed;
    cap_word[`HBACAP_RSVD_BIT] = 1'b0; // see RQ21
    cap_word[`HBACAP_NATIVE_BIT] = strap_fields.native_only_flag;
    cap_word[`HBACAP_MULT_BIT] = strap_fields.multiplier_supported;
    cap_word[`HBACAP_FRAME_BIT] = strap_fields.frame_switching_supported;
    cap_word[`HBACAP_PIO_BIT] = strap_fields.multi_block_pio;
    cap_word[`HBACAP_DEEP_BIT] = strap_fields.deep_sleep_capable;
    cap_word[`HBACAP_LIGHT_BIT] = strap_fields.light_sleep_capable;
    cap_word[`HBACAP_SLOT_HI:`HBACAP_SLOT_LO] = strap_fields.slot_count_m1;
    cap_word[`HBACAP_COAL_BIT] = strap_fields.coalescing_supported;
    cap_word[`HBACAP_ENCL_BIT] = strap_fields.enclosure_mgmt_supported;
    cap_word[`HBACAP_EXT_BIT] = strap_fields.external_port_present;
    // no check against the available-ports bitmap: it may be smaller
    cap_word[`HBACAP_PORT_HI:`HBACAP_PORT_LO] = strap_fields.port_count_m1; // see RQ19
  end

  hbacap_word_reg u_word (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_pulse),
    .load_word(cap_word),
    .rd_hit(rd_hit),
    .rd_data(word_rdata)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = word_rdata;
  assign reg_ack = st_r.ack;
  assign caps_valid = (st_r.phase == HBACAP_PH_RUN);
  assign max_link_speed = st_r.fields.max_link_speed;
  assign native_only_flag = st_r.fields.native_only_flag;
  assign multiplier_supported = st_r.fields.multiplier_supported;
  assign frame_switching_supported = st_r.fields.frame_switching_supported;
  assign multi_block_pio = st_r.fields.multi_block_pio;
  assign deep_sleep_capable = st_r.fields.deep_sleep_capable;
  assign light_sleep_capable = st_r.fields.light_sleep_capable;
  // one shared count fans out to all ports, so they cannot differ
  assign slot_count_m1 = st_r.fields.slot_count_m1; // see RQ13
  assign coalescing_regs_present = st_r.fields.coalescing_supported; // see RQ14
  assign enclosure_regs_present = st_r.fields.enclosure_mgmt_supported; // see RQ15
  assign external_port_present = st_r.fields.external_port_present;
  assign port_count_m1 = st_r.fields.port_count_m1;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_read_answer: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_ack && reg_rdata[`HBACAP_PORT_HI:`HBACAP_PORT_LO] == port_count_m1)
    else $error("capability read not answered next cycle");

  a_miss_zero: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    reg_rd && !rd_hit |=> reg_ack && reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero");

  a_speed_legal: assert property ( // see RQ2
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_SPD_HI:`HBACAP_SPD_LO] inside {4'h1, 4'h2, 4'h3})
    else $error("reserved speed encoding reported");

  a_native_flag: assert property ( // see RQ3
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_NATIVE_BIT] == native_only_flag)
    else $error("native-only bit mismatch");

  a_mult_flag: assert property ( // see RQ4
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_MULT_BIT] == multiplier_supported)
    else $error("multiplier bit mismatch");

  a_frame_needs_mult: assert property ( // see RQ5
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid ##1 reg_rdata[`HBACAP_FRAME_BIT] |-> reg_rdata[`HBACAP_MULT_BIT] && frame_switching_supported)
    else $error("frame switching without multiplier");

  a_pio_multi: assert property ( // see RQ6 see RQ7
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_PIO_BIT] && multi_block_pio)
    else $error("multi-block pio bit not one");

  a_sleep_flags: assert property ( // see RQ8 see RQ10
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_DEEP_BIT] == deep_sleep_capable
              && reg_rdata[`HBACAP_LIGHT_BIT] == light_sleep_capable)
    else $error("sleep capability bits mismatch");

  a_slot_count: assert property ( // see RQ12 see RQ13
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_SLOT_HI:`HBACAP_SLOT_LO] == slot_count_m1)
    else $error("slot count field mismatch");

  a_feature_regs: assert property ( // see RQ14 see RQ15 see RQ16
    @(posedge clk) disable iff (!rst_n)
    rd_hit && caps_valid |=> reg_rdata[`HBACAP_COAL_BIT] == coalescing_regs_present
              && reg_rdata[`HBACAP_ENCL_BIT] == enclosure_regs_present
              && reg_rdata[`HBACAP_EXT_BIT] == external_port_present)
    else $error("feature presence bits mismatch");

  a_port_count: assert property ( // see RQ17 see RQ18
    @(posedge clk) disable iff (!rst_n)
    caps_valid ##1 (rd_hit && caps_valid) |=> reg_rdata[`HBACAP_PORT_HI:`HBACAP_PORT_LO] == $past(port_count_m1, 2))
    else $error("port count field mismatch");

  a_write_ignored: assert property ( // see RQ20
    @(posedge clk) disable iff (!rst_n)
    caps_valid && reg_wr |=> reg_ack && $stable(st_r.fields) ##1 $stable(st_r.fields))
    else $error("write altered the capability fields");

  a_fields_frozen: assert property ( // see RQ20
    @(posedge clk) disable iff (!rst_n)
    caps_valid ##1 caps_valid |-> $stable(st_r.fields))
    else $error("capability fields changed after load");

  a_reserved_zero: assert property ( // see RQ21
    @(posedge clk) disable iff (!rst_n)
    reg_ack |-> reg_rdata[`HBACAP_RSVD_BIT] == 1'b0 && reg_rdata[31:24] == 8'h00)
    else $error("reserved bits read nonzero");

  a_ack_follows: assert property ( // see RQ20
    @(posedge clk) disable iff (!rst_n)
    reg_rd || reg_wr |=> reg_ack)
    else $error("access not acknowledged");

  a_ack_single: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    !(reg_rd || reg_wr) |=> !reg_ack)
    else $error("acknowledge without access");

  a_idle_zero: assert property ( // see RQ1
    @(posedge clk) disable iff (!rst_n)
    !rd_hit |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero without a hit");

  a_wr_rdata_zero: assert property ( // see RQ20
    @(posedge clk) disable iff (!rst_n)
    reg_wr && !reg_rd |=> reg_ack && reg_rdata == 32'h0000_0000)
    else $error("write returned read data");

  a_speed_field: assert property ( // see RQ2
    @(posedge clk) disable iff (!rst_n)
    caps_valid |-> max_link_speed inside {`HBACAP_SPEED_GEN1, `HBACAP_SPEED_GEN2, `HBACAP_SPEED_GEN3})
    else $error("reserved speed code on field output");

  a_frame_masked: assert property ( // see RQ5
    @(posedge clk) disable iff (!rst_n)
    caps_valid && frame_switching_supported |-> multiplier_supported)
    else $error("frame switching output without multiplier");

  a_pio_field: assert property ( // see RQ7
    @(posedge clk) disable iff (!rst_n)
    caps_valid |-> multi_block_pio)
    else $error("multi-block pio output not one");

  a_valid_holds: assert property ( // see RQ20
    @(posedge clk) disable iff (!rst_n)
    caps_valid |=> caps_valid)
    else $error("capture flag dropped before reset");

  // the capture edge is the only moment the straps matter
  a_load_capture: assert property ( // see RQ12 see RQ17
    @(posedge clk) disable iff (!rst_n)
    $rose(caps_valid) |-> st_r.fields == $past(strap_fields))
    else $error("captured fields differ from straps");

endmodule // hbacap_top

// ==== sim/hbacap_tb.sv ====
`timescale 1ns/1ps
`include "hbacap_cfg.svh"

module testbench;
  import hbacap_pkg::*;
  logic clk, rst_n, reg_rd, reg_wr, reg_ack, caps_valid;
  logic [`HBACAP_ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, exp_w, fields_w;
  logic [3:0] s_spd, max_link_speed;
  logic s_nat, s_mul, s_frm, s_deep, s_light, s_coal, s_encl, s_ext;
  logic native_only_flag, multiplier_supported, frame_switching_supported, multi_block_pio;
  logic deep_sleep_capable, light_sleep_capable, coalescing_regs_present, enclosure_regs_present;
  logic external_port_present;
  logic [4:0] s_slots, s_ports, slot_count_m1, port_count_m1;
  int mismatches, tests_run;

  hbacap_top i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .strap_max_speed(s_spd), .strap_native_only(s_nat), .strap_multiplier(s_mul),
    .strap_frame_switch(s_frm), .strap_deep_sleep(s_deep), .strap_light_sleep(s_light),
    .strap_slot_count_m1(s_slots), .strap_coalescing(s_coal), .strap_enclosure(s_encl),
    .strap_external_port(s_ext), .strap_port_count_m1(s_ports), .caps_valid(caps_valid),
    .max_link_speed(max_link_speed), .native_only_flag(native_only_flag),
    .multiplier_supported(multiplier_supported), .frame_switching_supported(frame_switching_supported),
    .multi_block_pio(multi_block_pio), .deep_sleep_capable(deep_sleep_capable),
    .light_sleep_capable(light_sleep_capable), .slot_count_m1(slot_count_m1),
    .coalescing_regs_present(coalescing_regs_present), .enclosure_regs_present(enclosure_regs_present),
    .external_port_present(external_port_present), .port_count_m1(port_count_m1)
  );

  // field outputs laid out as the word so one compare covers them all
  assign fields_w = {8'h00, max_link_speed, 1'b0, native_only_flag, multiplier_supported,
    frame_switching_supported, multi_block_pio, deep_sleep_capable, light_sleep_capable,
    slot_count_m1, coalescing_regs_present, enclosure_regs_present, external_port_present, port_count_m1};

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [31:0] model_word();
    int spd;
    int w;
    spd = s_spd;
    // reserved speed codes fall back to first generation
    if (spd == 0 || spd > 3) spd = 1;
    w = (spd << 20) | (s_nat << 18) | (s_mul << 17) | ((s_frm & s_mul) << 16) | (1 << 15);
    w = w | (s_deep << 14) | (s_light << 13) | (s_slots << 8) | (s_coal << 7) | (s_encl << 6);
    w = w | (s_ext << 5) | s_ports;
    return 32'(w);
  endfunction

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic check_data(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic check_bit(input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one access; answer appears on the taking edge and stands one cycle
  task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= rd;
    reg_wr <= wr;
    reg_addr <= a;
    reg_wdata <= $urandom;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    check_bit(1'b1, reg_ack);
    check_data(exp, reg_rdata);
    @(posedge clk);
    #1;
    check_bit(1'b0, reg_ack);
    check_data(32'h0000_0000, reg_rdata);
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial begin
    logic [7:0] a;
    logic [21:0] sv;
    rst_n = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    {s_spd, s_nat, s_mul, s_frm, s_deep, s_light, s_slots, s_coal, s_encl, s_ext, s_ports} = '0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(32'ha0fd));
    for (int i = 0; i < 18; i++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      // every speed code once, then the all-zero and all-one strap corners
      sv = 22'($urandom);
      if (i < 16) sv[21:18] = 4'(i);
      if (i == 16) sv = '0;
      if (i == 17) sv = '1;
      {s_spd, s_nat, s_mul, s_frm, s_deep, s_light, s_slots, s_coal, s_encl, s_ext, s_ports} <= sv;
      repeat (4) @(posedge clk);
      #1;
      check_bit(1'b0, caps_valid);
      check_data(32'h0000_0000, fields_w);
      exp_w = model_word();
      @(negedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check_bit(1'b1, caps_valid);
      check_data(exp_w, fields_w);
      // straps moving after capture must not reach the word
      {s_spd, s_nat, s_mul, s_frm, s_deep, s_light, s_slots, s_coal, s_encl, s_ext, s_ports} <= 22'($urandom);
      access(1'b1, 1'b0, `HBACAP_OFS_CAPS | 8'(i % 4), exp_w);
      a = 8'(($urandom % 252) + 4);
      access(1'b1, 1'b0, a, 32'h0000_0000);
      access(1'b0, 1'b1, `HBACAP_OFS_CAPS, 32'h0000_0000);
      access(1'b1, 1'b1, `HBACAP_OFS_CAPS, exp_w);
      check_data(exp_w, fields_w);
      // back-to-back reads: mapped then unmapped
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= `HBACAP_OFS_CAPS;
      @(posedge clk);
      reg_addr <= 8'h14;
      #1;
      check_bit(1'b1, reg_ack);
      check_data(exp_w, reg_rdata);
      // the driver decides its sleep policy from these read bits alone
      check_bit(exp_w[14], reg_rdata[`HBACAP_DEEP_BIT]);
      check_bit(exp_w[13], reg_rdata[`HBACAP_LIGHT_BIT]);
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check_bit(1'b1, reg_ack);
      check_data(32'h0000_0000, reg_rdata);
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule // testbench
